// ==== logic/fault_io_snapshot_pkg.sv ====
// Constants for the fault input/output snapshot register bank.
// Assumes a controller that pulses a fault event and reads the words by index.
package fault_io_snapshot_pkg;
	localparam int INPUT_COUNT = 8;
	localparam int OUTPUT_COUNT = 5;
	localparam int WORD_WIDTH = 16;
	localparam int HEX_DIGITS = 4;
	localparam logic [0:0] SEL_INPUT_SNAPSHOT = 1'h0;
	localparam logic [0:0] SEL_OUTPUT_SNAPSHOT = 1'h1;
	localparam logic [15:0] SNAPSHOT_RESET = 16'h0000;
	localparam logic [31:0] HEX_RESET = 32'h30303030;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] ASCII_LETTER_BASE = 8'h37;
	localparam logic [3:0] HEX_LETTER_MIN = 4'hA;
endpackage

// ==== logic/fault_io_snapshot.sv ====
// Fault snapshot of digital input and output levels, two read-only 16-bit words.
// Assumes faultEvent is a one-cycle pulse from core_clk logic; line inputs come from pins.
// Assumes the output line levels are produced by core_clk logic and need no sync.
// Assumes the reader holds readSelect and takes readData one clock later.
//
// Behaviour
// R1: On a fault, inputs one to eight are stored in input word bits 0 to 7.
// R2: A stored one means the line was active, zero means inactive.
// R3: Input word bits 8 to 15 always read zero.
// R4: On a fault, outputs one to five are stored in output word bits 0 to 4.
// R5: Output word bits 5 to 15 always read zero.
// R6: The selected word is also shown as four hex digits, least significant digit in the low byte.
// R7: Words hold between faults; reads have no side effect; writes are ignored.
`timescale 1ns/1ps
module fault_io_snapshot
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic faultEvent,
	input wire logic [7:0] digitalInputLine,
	input wire logic [4:0] digital_output_line,
	input wire logic readSelect,
	output logic [15:0] readData,
	output logic [15:0] fault_input_snapshot,
	output logic [15:0] fault_output_snapshot,
	output logic [31:0] readHexAscii
);
	logic [7:0] inSync1_r;
	logic [7:0] inSync2_r;
	logic [7:0] inSnap_r;
	logic [4:0] outSnap_r;
	logic [15:0] readData_nxt;
	logic [31:0] readHex_nxt;

	// Input pins cross into core_clk; outputs are our own logic so need no sync
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			inSync1_r <= 8'h00;
			inSync2_r <= 8'h00;
		end
		else
		begin
			inSync1_r <= digitalInputLine;
			inSync2_r <= inSync1_r;
		end
	end

	// Inputs come from the second sync stage, so a pin edge needs two clocks
	// before a fault can see it; a faster fault stores the older level
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			inSnap_r <= fault_io_snapshot_pkg::SNAPSHOT_RESET[7:0];
		end
		else if (faultEvent)
		begin
			inSnap_r <= inSync2_r; // R1 R2
		end
	end // R7

	// Output levels are our own core_clk logic, so they are taken as they stand
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			outSnap_r <= fault_io_snapshot_pkg::SNAPSHOT_RESET[4:0];
		end
		else if (faultEvent)
		begin
			outSnap_r <= digital_output_line; // R4 R2
		end
	end // R7

	assign fault_input_snapshot = {8'h00, inSnap_r}; // R3
	assign fault_output_snapshot = {11'h000, outSnap_r}; // R5

	// Selected word feeds both the binary and the text read paths
	always_comb
	begin
		readData_nxt = fault_input_snapshot;
		if (readSelect == fault_io_snapshot_pkg::SEL_OUTPUT_SNAPSHOT)
		begin
			readData_nxt = fault_output_snapshot;
		end
	end

	// One text byte per hex digit, upper-case letters as the keypad shows them
	for (genvar d = 0; d < fault_io_snapshot_pkg::HEX_DIGITS; d++)
	begin : g_hex
		logic [3:0] nib;
		logic [7:0] digitText;
		logic [7:0] letterText;

		assign nib = readData_nxt[d*4 +: 4];
		assign digitText = fault_io_snapshot_pkg::ASCII_ZERO + {4'h0, nib};
		assign letterText = fault_io_snapshot_pkg::ASCII_LETTER_BASE + {4'h0, nib};
		assign readHex_nxt[d*8 +: 8] = (nib < fault_io_snapshot_pkg::HEX_LETTER_MIN) ? digitText : letterText; // R6

		// Decode the text back against the binary word registered beside it
		hex_text_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
			((readData[d*4 +: 4] < 4'hA) && (readHexAscii[d*8 +: 8] == {4'h3, readData[d*4 +: 4]}))
			|| ((readData[d*4 +: 4] >= 4'hA) && (readHexAscii[d*8 +: 8] == (8'h40 + {4'h0, readData[d*4 +: 4]} - 8'h09))))
			else $error("hex text does not match read word");
	end

	// Registered read port; reads change no state
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			readData <= fault_io_snapshot_pkg::SNAPSHOT_RESET;
			readHexAscii <= fault_io_snapshot_pkg::HEX_RESET;
		end
		else
		begin
			readData <= readData_nxt; // R7
			readHexAscii <= readHex_nxt; // R6
		end
	end

	in_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		!faultEvent |=> $stable(fault_input_snapshot) && $stable(fault_output_snapshot))
		else $error("snapshot changed without fault");
	in_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		faultEvent |=> fault_input_snapshot[7:0] == $past(inSync2_r))
		else $error("input snapshot wrong");
	out_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
		faultEvent |=> fault_output_snapshot[4:0] == $past(digital_output_line))
		else $error("output snapshot wrong");
	in_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3
		fault_input_snapshot[15:8] == 8'h00)
		else $error("input upper bits nonzero");
	out_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
		fault_output_snapshot[15:5] == 11'h000)
		else $error("output upper bits nonzero");
	// The antecedent keeps the release edge out: the word there is still the reset one
	read_data_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		!sys_rst |=> readData == ($past(readSelect) ? $past(fault_output_snapshot) : $past(fault_input_snapshot)))
		else $error("read data mismatch");

	hex_top_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
		##1 readHexAscii[31:16] == 16'h3030)
		else $error("upper hex digits not zero");
	active_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		faultEvent && inSync2_r[0] |=> fault_input_snapshot[0] == 1'b1)
		else $error("active line not stored as one");

	in_inactive_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		faultEvent && !inSync2_r[7] |=> fault_input_snapshot[7] == 1'b0)
		else $error("inactive line not stored as zero");

	out_active_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		faultEvent && digital_output_line[4] |=> fault_output_snapshot[4] == 1'b1)
		else $error("active output not stored as one");

	out_inactive_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
		faultEvent && !digital_output_line[0] |=> fault_output_snapshot[0] == 1'b0)
		else $error("inactive output not stored as zero");

	read_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R3 R5
		readData[15:8] == 8'h00)
		else $error("read word upper byte nonzero");

	// Everything a reader can see must be back at its reset value after a reset edge
	reset_state_a: assert property (@(posedge core_clk) // R7
		sys_rst |=> (readData == fault_io_snapshot_pkg::SNAPSHOT_RESET)
			&& (readHexAscii == fault_io_snapshot_pkg::HEX_RESET)
			&& (fault_input_snapshot == fault_io_snapshot_pkg::SNAPSHOT_RESET)
			&& (fault_output_snapshot == fault_io_snapshot_pkg::SNAPSHOT_RESET))
		else $error("state not cleared by reset");

	// Two flops exactly: one more would let a fault miss a level the pins held
	sync_pipe_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
		!sys_rst |-> ##2 inSync2_r == $past(digitalInputLine, 2))
		else $error("input sync latency wrong");

	// Bit placement, one check per line so a swapped pair cannot hide
	for (genvar i = 0; i < fault_io_snapshot_pkg::INPUT_COUNT; i++)
	begin : g_in_bit
		in_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
			faultEvent |=> fault_input_snapshot[i] == $past(inSync2_r[i]))
			else $error("input bit stored in wrong place");
	end

	for (genvar i = 0; i < fault_io_snapshot_pkg::OUTPUT_COUNT; i++)
	begin : g_out_bit
		out_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
			faultEvent |=> fault_output_snapshot[i] == $past(digital_output_line[i]))
			else $error("output bit stored in wrong place");
	end

	// Back-to-back faults: the second one must overwrite the first in the output word
	last_wins_a: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
		faultEvent ##1 faultEvent |=> fault_output_snapshot[4:0] == $past(digital_output_line))
		else $error("later fault did not win");
endmodule

// ==== verif/fault_io_snapshot_tb.sv ====
// Self-checking bench for the fault snapshot bank.
// Assumes the design files under logic/ are compiled first.
`timescale 1ns/1ps
module fault_io_snapshot_tb;
	logic core_clk = 0, sys_rst = 1, faultEvent = 0, readSelect = 0, chk = 0;
	logic [7:0] inLine = 8'h00;
	logic [4:0] outLine = 5'h00;
	logic [15:0] rdData, inSnap, outSnap, expIn, expOut;
	logic [31:0] r, hexOut;
	logic [79:0] notes[$];
	logic [79:0] note;
	int fails = 0, tests_run = 0, cycles = 0, seed = 59442;
	fault_io_snapshot DUT (.core_clk(core_clk), .sys_rst(sys_rst), .faultEvent(faultEvent),
		.digitalInputLine(inLine), .digital_output_line(outLine), .readSelect(readSelect),
		.readData(rdData), .fault_input_snapshot(inSnap), .fault_output_snapshot(outSnap), .readHexAscii(hexOut));
	// Keypad text as the reader expects it, least significant digit in the low byte
	function automatic logic [31:0] hex_text(logic [15:0] w);
		logic [31:0] t;
		t = 32'h00000000;
		for (int d = 0; d < 4; d++)
			t[d*8 +: 8] = (w[d*4 +: 4] > 4'h9) ? 8'h41 + (w[d*4 +: 4] - 8'h0A) : 8'h30 + w[d*4 +: 4];
		return t;
	endfunction
	task automatic expect_now;
		logic [15:0] w;
		w = readSelect ? expOut : expIn;
		notes.push_back({expIn, expOut, w, hex_text(w)});
		chk <= 1;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			wrap_up();
		end
		if (chk)
		begin
			note = notes.pop_front();
			check("inWord", {16'h0000, inSnap}, {16'h0000, note[79:64]});
			check("outWord", {16'h0000, outSnap}, {16'h0000, note[63:48]});
			check("readData", {16'h0000, rdData}, {16'h0000, note[47:32]});
			check("readHex", hexOut, note[31:0]);
		end
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 0;
		expIn = 16'h0000;
		expOut = 16'h0000;
		expect_now();
		@(posedge core_clk);
		chk <= 0;
		repeat (20)
		begin
			@(posedge core_clk);
			r = $random(seed);
			inLine <= r[7:0];
			outLine <= r[12:8];
			readSelect <= r[13];
			// Pins settle past the two-flop sync before the fault
			repeat (3) @(posedge core_clk);
			faultEvent <= 1;
			expIn = {8'h00, inLine};
			expOut = {11'h000, outLine};
			@(posedge core_clk);
			faultEvent <= 0;
			r = $random(seed);
			inLine <= r[7:0];
			outLine <= r[12:8];
			repeat (3) @(posedge core_clk);
			expect_now();
			@(posedge core_clk);
			chk <= 0;
		end
		// Two faults in a row with the outputs moving: the later levels stay
		@(posedge core_clk);
		r = $random(seed);
		inLine <= r[7:0];
		outLine <= r[12:8];
		repeat (3) @(posedge core_clk);
		faultEvent <= 1;
		outLine <= r[20:16];
		@(posedge core_clk);
		outLine <= r[28:24];
		@(posedge core_clk);
		faultEvent <= 0;
		expIn = {8'h00, inLine};
		expOut = {11'h000, outLine};
		repeat (3) @(posedge core_clk);
		expect_now();
		@(posedge core_clk);
		chk <= 0;
		// Reset in mid-run clears what was captured
		sys_rst <= 1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 0;
		expIn = 16'h0000;
		expOut = 16'h0000;
		expect_now();
		@(posedge core_clk);
		chk <= 0;
		@(posedge core_clk);
		wrap_up();
	end
endmodule
